// [inc/host_port_pkg.sv]
// Package: constants and carrier types for the host port and radio pins
package host_port_pkg;
	localparam int ADDR_W    = 4;
	localparam int DATA_W    = 8;
	localparam int SYNC_LEN  = 3;
	localparam int CHIP_DIV  = 8;
	localparam int REG_COUNT = 16;

	localparam logic [3:0] ADDR_IRQ_SRC  = 4'hF;
	localparam logic [3:0] ADDR_RX_CHIPS = 4'hE;
	localparam logic [3:0] ADDR_CTRL     = 4'h0;
	localparam logic [3:0] ADDR_TX_DATA  = 4'h1;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;

	localparam int CTRL_TX_BIT  = 0;
	localparam int IRQ_RX_BIT   = 0;
	localparam int IRQ_TX_BIT   = 1;

	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [2:0] ZERO3     = 3'h0;
	localparam logic [2:0] ONE3      = 3'h1;
	localparam logic [2:0] DIV_LAST  = 3'h7;

	typedef struct packed {
		logic       selN;
		logic       rdN;
		logic       wrN;
		logic [3:0] addr;
		logic [7:0] dataIn;
	} host_req_type;

	typedef struct packed {
		logic [7:0] dataOut;
		logic       dataOe;
		logic       irqN;
	} host_ans_type;

	typedef struct packed {
		logic antennaTxSelect;
		logic modulatedChipOut;
	} radio_out_type;
endpackage

// [src/pin_sync.sv]
// Three-stage synchroniser with agreement of last two stages
module pin_sync
	import host_port_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic pinIn,
	output logic      pinOut
);
	typedef struct packed {
		logic [2:0] sh;
		logic       stable;
	} sync_state_type;

	sync_state_type state_r;
	sync_state_type state_nxt;

	always_comb begin
		state_nxt = state_r;
		state_nxt.sh = {state_r.sh[1:0], pinIn};
		// Stage 0 only feeds stage 1; stages 1 and 2 must agree
		if (state_r.sh[2] == state_r.sh[1]) begin
			state_nxt.stable = state_r.sh[2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign pinOut = state_r.stable;
endmodule

// [src/host_bus_and_radio_pins.sv]
// Host parallel port and radio-side digital pins of the transceiver
// Notes on behaviour
// RULE_01 - Antenna select high means transmit, low receive
// RULE_02 - Modulated chips leave on dedicated output
// RULE_03 - Received chips come on one digital input
// RULE_04 - Reset low clears storage, stops divided clocks
// RULE_05 - Address valid only while select is low
// RULE_06 - Select high: host accesses change nothing
// RULE_07 - Four-bit address, bit 3 most significant
// RULE_08 - Interrupt low while pending; host reads source
// RULE_09 - Eight-bit two-way data bus, bit 7 top
// RULE_10 - Drive data only on selected read
module host_bus_and_radio_pins
	import host_port_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             master_reset_n,
	input  wire logic             device_select_n,
	input  wire logic             host_rd_n,
	input  wire logic             host_wr_n,
	input  wire logic [ADDR_W-1:0] host_addr,
	input  wire logic [DATA_W-1:0] host_data_in,
	output logic      [DATA_W-1:0] host_data_out,
	output logic      [DATA_W-1:0] host_data_oe_n,
	output logic                  host_irq_n,
	input  wire logic             rx_chip_in,
	output logic                  antenna_tx_select,
	output logic                  modulated_chip_out
);
	typedef struct packed {
		host_req_type  req;
		logic          rdPrev;
		logic          wrPrev;
		logic [7:0]    ctrl;
		logic [7:0]    txShift;
		logic [7:0]    rxShift;
		logic [7:0]    rxHold;
		logic [2:0]    div;
		logic [2:0]    rxCount;
		logic [2:0]    txCount;
		logic [7:0]    irqSrc;
		logic [7:0]    irqMask;
		host_ans_type  ans;
		radio_out_type radio;
	} port_state_type;

	port_state_type state_r;
	port_state_type state_nxt;

	// Strobes after synchronisation, active high and active low
	logic           selAct;
	logic           rdAct;
	logic           wrAct;
	logic           selN;
	logic           rdN;
	logic           wrN;
	logic           rxChip;
	logic           chipTick;
	logic           rdFall;
	logic           wrRise;
	logic           selRead;
	// Events, each true for one clock
	logic           wrFall;
	logic           rxDone;
	logic           txDone;

	// Host strobes come from another clock: synchronise them active high,
	// so a synchroniser's reset value is the idle level and no false
	// access follows reset
	// Data lines are qualified by the strobes and need no synchroniser
	pin_sync uSel (
		.clk_sys(clk_sys),
		.rstn   (master_reset_n),
		.pinIn  (~device_select_n),
		.pinOut (selAct)
	);

	pin_sync uRd (
		.clk_sys(clk_sys),
		.rstn   (master_reset_n),
		.pinIn  (~host_rd_n),
		.pinOut (rdAct)
	);

	pin_sync uWr (
		.clk_sys(clk_sys),
		.rstn   (master_reset_n),
		.pinIn  (~host_wr_n),
		.pinOut (wrAct)
	);

	pin_sync uRx (
		.clk_sys(clk_sys),
		.rstn   (master_reset_n),
		.pinIn  (rx_chip_in), // RULE_03
		.pinOut (rxChip)
	);

	// Back to pin polarity for the access logic
	assign selN     = ~selAct;
	assign rdN      = ~rdAct;
	assign wrN      = ~wrAct;

	// Chip divider: one tick in eight clocks
	assign chipTick = (state_r.div == DIV_LAST);
	assign rxDone   = chipTick && (state_r.rxCount == DIV_LAST);
	assign txDone   = chipTick && (state_r.txCount == DIV_LAST);

	// A read or write counts only while selected
	assign selRead  = !selN && !rdN; // RULE_05
	assign rdFall   = selRead && state_r.rdPrev;
	assign wrFall   = !selN && !wrN && state_r.wrPrev;
	assign wrRise   = wrN && !state_r.wrPrev && !selN; // RULE_06

	always_comb begin
		state_nxt = state_r;
		state_nxt.rdPrev = rdN || selN;
		state_nxt.wrPrev = wrN || selN;
		state_nxt.div    = state_r.div + ONE3;

		// Address held steady by the host for the whole access
		if (!selN) begin
			state_nxt.req.addr = host_addr; // RULE_07
		end

		// Write data is taken once, at strobe start: the host may let
		// the bus go as soon as it lifts the strobe
		if (wrFall) begin
			state_nxt.req.dataIn = host_data_in; // RULE_09
		end

		// Chips move one place per divider tick
		if (chipTick) begin
			state_nxt.rxShift = {state_r.rxShift[6:0], rxChip}; // RULE_03
			state_nxt.rxCount = state_r.rxCount + ONE3;
			state_nxt.txShift = {state_r.txShift[6:0], 1'b0};
			state_nxt.txCount = state_r.txCount + ONE3;
			state_nxt.radio.modulatedChipOut = state_r.txShift[7]; // RULE_02
		end
		if (rxDone) begin
			state_nxt.rxHold = {state_r.rxShift[6:0], rxChip};
		end

		// Reading the source clears it; an event in the same cycle wins
		if (rdFall && state_nxt.req.addr == ADDR_IRQ_SRC) begin // RULE_08
			state_nxt.irqSrc = ZERO_BYTE;
		end
		if (rxDone) begin
			state_nxt.irqSrc[IRQ_RX_BIT] = 1'b1;
		end
		if (txDone) begin
			state_nxt.irqSrc[IRQ_TX_BIT] = 1'b1;
		end

		if (wrRise) begin // RULE_06
			unique case (state_r.req.addr)
				ADDR_CTRL: begin
					state_nxt.ctrl = state_r.req.dataIn;
				end
				ADDR_TX_DATA: begin
					state_nxt.txShift = state_r.req.dataIn;
					state_nxt.txCount = ZERO3;
				end
				ADDR_IRQ_MASK: begin
					state_nxt.irqMask = state_r.req.dataIn;
				end
				default: begin
					state_nxt.ctrl = state_r.ctrl;
				end
			endcase
		end

		// Read data is taken at strobe start and stands to its end, so a
		// read that clears the source still shows what was pending
		if (rdFall) begin
			unique case (state_nxt.req.addr)
				ADDR_CTRL: begin
					state_nxt.ans.dataOut = state_r.ctrl;
				end
				ADDR_IRQ_MASK: begin
					state_nxt.ans.dataOut = state_r.irqMask;
				end
				ADDR_RX_CHIPS: begin
					state_nxt.ans.dataOut = state_r.rxHold;
				end
				ADDR_IRQ_SRC: begin
					state_nxt.ans.dataOut = state_r.irqSrc;
				end
				default: begin
					state_nxt.ans.dataOut = ZERO_BYTE;
				end
			endcase
		end

		// Bus is let go one clock after the strobe or select lifts
		state_nxt.ans.dataOe = selRead; // RULE_10
		state_nxt.ans.irqN =
			~|(state_nxt.irqSrc & state_nxt.irqMask); // RULE_08
		// Antenna follows the control write in the same clock
		state_nxt.radio.antennaTxSelect =
			state_nxt.ctrl[CTRL_TX_BIT]; // RULE_01
	end

	// Synchronous reset clears state but sets rdPrev, wrPrev and irqN high, and holds the chip divider
	always_ff @(posedge clk_sys) begin
		if (!master_reset_n) begin // RULE_04
			state_r        <= '0;
			state_r.rdPrev <= 1'b1;
			state_r.wrPrev <= 1'b1;
			state_r.ans.irqN <= 1'b1;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign host_data_out      = state_r.ans.dataOut; // RULE_09

	// Every data bit shares the one enable flop
	for (genvar b = 0; b < DATA_W; b++) begin : gen_oe
		assign host_data_oe_n[b] = ~state_r.ans.dataOe; // RULE_10
	end
	assign host_irq_n         = state_r.ans.irqN;
	assign antenna_tx_select  = state_r.radio.antennaTxSelect; // RULE_01
	assign modulated_chip_out = state_r.radio.modulatedChipOut; // RULE_02
endmodule

// [verif/host_bus_checker.sv]
// Concurrent checks on the host port and radio pins
module host_bus_checker
	import host_port_pkg::*;
(
	input wire logic       clk_sys, master_reset_n, device_select_n,
	input wire logic       host_rd_n, host_wr_n, rx_chip_in,
	input wire logic [3:0] host_addr,
	input wire logic [7:0] host_data_in, host_data_out, host_data_oe_n,
	input wire logic       host_irq_n, antenna_tx_select, modulated_chip_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!master_reset_n);
	sel_idle_a: assert property (device_select_n [*7] |-> &host_data_oe_n)
		else $error("bus driven unselected");
	rd_idle_a: assert property (host_rd_n [*7] |-> &host_data_oe_n)
		else $error("bus driven without read");
	oe_whole_a: assert property (&host_data_oe_n || !(|host_data_oe_n))
		else $error("partial byte drive");
	read_drive_a: assert property ((!device_select_n && !host_rd_n) [*6]
		|-> host_data_oe_n == 8'h00) else $error("read not answered");
	oe_release_a: assert property ($rose(host_rd_n) |-> ##6 &host_data_oe_n)
		else $error("bus held after read");
	reset_clear_a: assert property (disable iff (1'b0) !master_reset_n
		|=> !antenna_tx_select && !modulated_chip_out && host_irq_n)
		else $error("state kept in reset");
	chip_step_a: assert property ($changed(modulated_chip_out)
		|=> $stable(modulated_chip_out) [*7]) else $error("chip too short");
	ant_cause_a: assert property ($changed(antenna_tx_select)
		|-> !device_select_n) else $error("antenna moved unselected");
endmodule

bind host_bus_and_radio_pins host_bus_checker chk (.*);

// [verif/host_cpu_model.sv]
// Host processor model driving the parallel port pins
module host_cpu_model
	import host_port_pkg::*;
(
	input  wire logic   clk_sys,
	output host_req_type req
);
	timeunit 1ns;
	timeprecision 1ps;
	host_req_type r = '{1'b1, 1'b1, 1'b1, 4'h0, 8'h00};
	logic [7:0]   noise;
	// Idle data changes each cycle so a stale byte never looks valid
	always @(negedge clk_sys) noise <= 8'($urandom);
	assign req = '{r.selN, r.rdN, r.wrN, r.addr, r.wrN ? noise : r.dataIn};
	task automatic access(input logic sel, rd, input logic [3:0] a,
		input logic [7:0] d);
		@(negedge clk_sys);
		r = '{!sel, !rd, rd, a, d};
		repeat (7) @(negedge clk_sys);
		{r.rdN, r.wrN} = 2'b11;
		repeat (6) @(negedge clk_sys);
		r.selN = 1'b1;
		repeat (6) @(negedge clk_sys);
	endtask
endmodule

// [verif/host_bus_and_radio_pins_tb.sv]
// Self-checking bench for the host port and radio pins
module host_bus_and_radio_pins_tb
	import host_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, master_reset_n = 1'b0, rx_chip_in = 1'b0;
	logic device_select_n, host_rd_n, host_wr_n, prevIdle = 1'b1;
	logic [3:0] host_addr;
	logic [7:0] host_data_in, host_data_out, host_data_oe_n, q[$];
	logic host_irq_n, antenna_tx_select, modulated_chip_out;
	logic [7:0] txByte, txSeen, txq[$];
	host_req_type req;
	int fail_count = 0, compares = 0;
	initial forever #5 clk_sys = ~clk_sys;
	host_cpu_model cpu (.clk_sys(clk_sys), .req(req));
	host_bus_and_radio_pins dut (.*);
	assign {device_select_n, host_rd_n, host_wr_n, host_addr} = req[14:8];
	// Wire level: device wins where its enable is low
	assign host_data_in = (~host_data_oe_n & host_data_out)
		| (host_data_oe_n & req.dataIn);
	always @(negedge clk_sys) rx_chip_in <= 1'($urandom);
	task automatic chk(input logic g, e, input string m);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t %s", $time, m);
		end
	endtask
	task automatic cmpb(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t read %h not %h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		q.push_back(e);
		cpu.access(1'b1, 1'b1, a, 8'h00);
	endtask
	always @(negedge clk_sys) begin
		if (host_data_oe_n === 8'h00 && prevIdle)
			cmpb(host_data_out, q.size() ? q.pop_front() : 8'hXX);
		prevIdle <= &host_data_oe_n;
	end
	// Chip watcher: the first high chip is bit 7, sampled mid-chip
	initial forever begin
		@(negedge clk_sys);
		if (txq.size() != 0 && modulated_chip_out === 1'b1) begin
			txSeen = txq.pop_front();
			repeat (4) @(negedge clk_sys);
			for (int k = 7; k >= 0; k--) begin
				chk(modulated_chip_out, txSeen[k], "chip out");
				repeat (8) @(negedge clk_sys);
			end
		end
	end
	task automatic conclude();
		$display("Compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		void'($urandom(62));
		repeat (5) @(negedge clk_sys);
		chk(antenna_tx_select | ~host_irq_n, 1'b0, "reset state");
		master_reset_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		cpu.access(1'b1, 1'b0, ADDR_CTRL, 8'h01);
		chk(antenna_tx_select, 1'b1, "antenna tx");
		cpu.access(1'b0, 1'b0, ADDR_CTRL, 8'h00);
		chk(antenna_tx_select, 1'b1, "unselected write");
		rd(ADDR_CTRL, 8'h01);
		rd(4'h5, ZERO_BYTE);
		cpu.access(1'b0, 1'b1, ADDR_CTRL, 8'h00);
		cpu.access(1'b1, 1'b0, ADDR_IRQ_MASK, 8'h02);
		rd(ADDR_IRQ_MASK, 8'h02);
		// Top bit set so the first high chip marks the byte start
		txByte = 8'($urandom) | 8'h80;
		txq.push_back(txByte);
		cpu.access(1'b1, 1'b0, ADDR_TX_DATA, txByte);
		repeat (80) @(negedge clk_sys);
		chk(host_irq_n, 1'b0, "tx irq");
		cpu.access(1'b1, 1'b0, ADDR_IRQ_MASK, 8'h00);
		chk(host_irq_n, 1'b1, "masked irq");
		cpu.access(1'b1, 1'b0, ADDR_CTRL, 8'h00);
		chk(antenna_tx_select, 1'b0, "antenna rx");
		// Both done events have been pending since the first byte period
		rd(ADDR_IRQ_SRC, 8'h03);
		conclude();
	end
	// Tests take about 3 us; a hang is cut well after that
	initial begin
		#20000;
		fail_count++;
		conclude();
	end
endmodule
